// [common/uhd_link_map.svh]
// register offsets, field positions, reset values and raster constants of the link mapper
`ifndef UHD_LINK_MAP_SVH
`define UHD_LINK_MAP_SVH
// ***********************************************************
// register offsets
// ***********************************************************
`define ADDR_CTRL 8'h00
`define ADDR_FMT 8'h04
`define ADDR_STATUS 8'h08
`define ADDR_CONN 8'h0C
// ***********************************************************
// fields and codes
// ***********************************************************
`define CTRL_START 0
`define CTRL_TX 1
`define CTRL_RX 2
`define CTRL_MODE_LO 3
`define CTRL_WIRES_LO 5
`define FMT_HFR 0
`define FMT_DEPTH_LO 1
`define FMT_CHROMA_LO 3
`define FMT_WIDE 5
`define CTRL_RST 32'h0000_0000
`define FMT_RST 6'h02
`define MODE_SINGLE 2'h0
`define MODE_QUAD 2'h1
`define MODE_INTERLEAVE 2'h2
`define WIRES_AUTO 2'h0
`define WIRES_TWO 2'h1
`define DEPTH_8 2'h0
`define DEPTH_12 2'h2
`define CHROMA_420 2'h0
`define CHROMA_444 2'h2
// ***********************************************************
// data rate in units of 1.5G, raster geometry
// ***********************************************************
`define UNITS_1G5 5'h01
`define UNITS_3G 5'h02
`define UNITS_6G 5'h04
`define UNITS_12G 5'h08
`define HALF_W_UHD 13'h0780
`define HALF_W_4K 13'h0800
`define HALF_H 13'h0438
`define FULL_H 13'h0870
`define PIX_W 20
`define FIFO_DEPTH 16
`endif

// [common/uhd_link_pkg.sv]
// types shared by the link mapper
package uhd_link_pkg;
  typedef enum logic [1:0] {XM_SINGLE, XM_QUAD, XM_INTERLEAVE} xmode_t;
  typedef enum logic [1:0] {RATE_1G5, RATE_3G, RATE_6G, RATE_12G} rate_t;
  typedef enum logic [1:0] {ST_IDLE, ST_CALC, ST_RUN} state_t;
  typedef struct packed {
    xmode_t mode;
    logic [2:0] links;
    rate_t rate;
  } xport_t;
endpackage

// [core/uhd_sdi_transport_link_mapper.sv]
// UHD/4K SDI transport mapper: link planning, connector arbitration, lane split and merge
// Behaviour
// - single-link carries the picture at 12G or 6G, both interleaved.
// - 12G versus 6G follows the data rate, never a user choice.
// - offers quadrant four-link, quadrant two-link and auto interleaved multi-link modes.
// - quadrant uses four 1.5G links up to 30fps, 3G for high rate or deep, 6G for high rate and deep together.
// - each link of quadrant four-link carries one spatial quarter of the raster.
// - interleave splits pixels into four subsampled copies on four links, two on two links, merged again on reception.
// - interleaved sub-streams above 30fps run at 6G, or at 12G when interleave is chosen automatically.
// - two-link mode puts half the picture on each link at higher rates.
// - too few links for the data rate raises the link count automatically.
// - up to 30fps on one or two links, input and output run together, two connectors each.
// - above 30fps one signal takes all four connectors.
// - high frame rate allows input or output, never both.
// - full-resolution HDMI for single-link and interleaved input; quadrant input is down-converted.
// - a configured output wire count forces quadrant mapping unless interleave mode is requested.
// - requested interleave ignores wire count and takes two links up to 12G of data, four above.
`timescale 1ns/1ns
`default_nettype none
`include "uhd_link_map.svh"

// ***********************************************************
// pixel fifo
// ***********************************************************
module xfer_fifo #(
  parameter int W = 22,
  parameter int D = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW:0] wp_r;
  logic [AW:0] rp_r;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  assign in_ready = !((wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]));
  assign out_valid = (wp_r != rp_r);
  assign out_data = mem[rp_r[AW-1:0]];
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp_r[AW-1:0]] <= in_data;
    end
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      if (push) begin
        wp_r <= wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= rp_r + 1'b1;
      end
    end
  end
endmodule

// ***********************************************************
// top
// ***********************************************************
module uhd_sdi_transport_link_mapper
  import uhd_link_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // pixel input for transmission, on the pixel clock
  input wire logic pix_clk,
  input wire logic pix_valid,
  input wire logic pix_sof,
  input wire logic pix_sol,
  input wire logic [`PIX_W-1:0] pix_data,
  output logic pix_ready,
  // sdi transmit lanes
  output logic [4*`PIX_W-1:0] tx_lane_data,
  output logic [3:0] tx_lane_valid,
  input wire logic link_ready,
  // sdi receive lanes, on the pixel clock
  input wire logic rx_valid,
  input wire logic [4*`PIX_W-1:0] rx_lane_data,
  output logic [`PIX_W-1:0] rx_pix_data,
  output logic rx_pix_valid,
  // connector use and hdmi path
  output logic [3:0] conn_in,
  output logic [3:0] conn_out,
  output logic hdmi_full_res,
  output logic hdmi_downconv
);
  localparam int SW = 4 + `PIX_W + 1 + 4 * `PIX_W;

  function automatic logic [4:0] data_units(input logic high_frame_rate, input logic [1:0] depth,
                                            input logic [1:0] chroma);
    logic [4:0] u;
    // high frame rate always doubles, so quadrant lanes reach 3g
    u = `UNITS_6G;
    if (depth == `DEPTH_12 || chroma == `CHROMA_444) begin
      u = `UNITS_12G;
    end
    if (high_frame_rate) begin
      u = {u[3:0], 1'b0};
    end
    return u;
  endfunction

  function automatic rate_t rate_of(input logic [4:0] per);
    if (per <= `UNITS_1G5) return RATE_1G5;
    else if (per <= `UNITS_3G) return RATE_3G;
    else if (per <= `UNITS_6G) return RATE_6G;
    else return RATE_12G;
  endfunction

  function automatic xport_t plan_xport(input logic [4:0] u, input logic [1:0] mreq,
                                        input logic [1:0] wreq, input logic tx);
    xport_t p;
    logic [4:0] per;
    p.mode = XM_SINGLE;
    p.links = 3'h1;
    if (mreq == `MODE_INTERLEAVE) begin
      p.mode = XM_INTERLEAVE;
      p.links = (u <= `UNITS_12G) ? 3'h2 : 3'h4;
    end else if (mreq == `MODE_QUAD || (tx && wreq != `WIRES_AUTO)) begin
      p.mode = XM_QUAD;
      p.links = (wreq == `WIRES_TWO && u <= `UNITS_12G) ? 3'h2 : 3'h4;
    end else if (u > `UNITS_12G) begin
      p.mode = XM_INTERLEAVE;
      p.links = 3'h2;
    end
    per = (p.links == 3'h4) ? (u >> 2) : (p.links == 3'h2) ? (u >> 1) : u;
    p.rate = rate_of(per);
    return p;
  endfunction

  function automatic logic [1:0] lane_of(input xport_t p, input logic [12:0] x,
                                         input logic [12:0] y, input logic [12:0] halfw);
    if (p.mode == XM_QUAD && p.links == 3'h4) return {y >= `HALF_H, x >= halfw};
    else if (p.mode == XM_QUAD && p.links == 3'h2) return {1'b0, y >= `HALF_H};
    else if (p.mode == XM_INTERLEAVE && p.links == 3'h4) return {y[0], x[0]};
    else if (p.mode == XM_INTERLEAVE) return {1'b0, y[0]};
    else return 2'h0;
  endfunction

  // ***********************************************************
  // registers and bus
  // ***********************************************************
  state_t state_r;
  state_t state_nxt;
  xport_t xport_r;
  logic [4:0] units_r;
  logic tx_en_r, rx_en_r, start_r, wr_pend_r, conflict_r, ovf_r;
  logic tx_go_r, rx_go_r;
  logic [1:0] mode_req_r, wires_r;
  logic [5:0] fmt_r;
  logic [7:0] wr_addr_r;
  logic [31:0] hrdata_r;
  logic [3:0] conn_in_r, conn_out_r;
  logic hdmi_full_res_r, hdmi_downconv_r;
  logic fifo_in_ready, fifo_out_valid;
  logic [`PIX_W+1:0] fifo_out_data;

  wire addr_ok = hsel && htrans[1] && hready;
  wire running = (state_r == ST_RUN);
  wire [31:0] ctrl_rd = {25'h0, wires_r, mode_req_r, rx_en_r, tx_en_r, 1'b0};
  wire [31:0] fmt_rd = {26'h0, fmt_r};
  wire [31:0] stat_rd = {20'h0, ovf_r, !fifo_in_ready, hdmi_full_res_r, xport_r.mode,
                         xport_r.rate, xport_r.links, conflict_r, running};
  wire [31:0] conn_rd = {24'h0, conn_out_r, conn_in_r};
  wire [31:0] rd_mux = (haddr[7:0] == `ADDR_CTRL) ? ctrl_rd :
                       (haddr[7:0] == `ADDR_FMT) ? fmt_rd :
                       (haddr[7:0] == `ADDR_STATUS) ? stat_rd :
                       (haddr[7:0] == `ADDR_CONN) ? conn_rd : 32'h0;
  wire wr_ctrl = wr_pend_r && (wr_addr_r == `ADDR_CTRL);
  wire wr_fmt = wr_pend_r && (wr_addr_r == `ADDR_FMT);
  wire [4:0] units_now = data_units(fmt_r[`FMT_HFR], fmt_r[`FMT_DEPTH_LO +: 2],
                                    fmt_r[`FMT_CHROMA_LO +: 2]);
  wire [12:0] halfw = fmt_r[`FMT_WIDE] ? `HALF_W_4K : `HALF_W_UHD;
  wire high_frame_rate = fmt_r[`FMT_HFR];

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      hrdata_r <= 32'h0;
      start_r <= 1'b0;
      tx_en_r <= 1'b0;
      rx_en_r <= 1'b0;
      mode_req_r <= `MODE_SINGLE;
      wires_r <= `WIRES_AUTO;
      fmt_r <= `FMT_RST;
    end else begin
      wr_pend_r <= addr_ok && hwrite;
      wr_addr_r <= haddr[7:0];
      if (addr_ok && !hwrite) begin
        hrdata_r <= rd_mux;
      end
      start_r <= wr_ctrl && hwdata[`CTRL_START];
      if (wr_ctrl) begin
        tx_en_r <= hwdata[`CTRL_TX];
        rx_en_r <= hwdata[`CTRL_RX];
        mode_req_r <= hwdata[`CTRL_MODE_LO +: 2];
        wires_r <= hwdata[`CTRL_WIRES_LO +: 2];
      end
      if (wr_fmt) begin
        fmt_r <= hwdata[5:0];
      end
    end
  end

  // ***********************************************************
  // planning and connector arbitration
  // ***********************************************************
  wire shared = tx_en_r && rx_en_r && !high_frame_rate && (xport_r.links <= 3'h2);
  wire [3:0] dir_mask = (high_frame_rate || xport_r.links == 3'h4) ? 4'hF :
                        (xport_r.links == 3'h2) ? 4'h3 : 4'h1;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (start_r) state_nxt = ST_CALC;
      end
      ST_CALC: begin
        state_nxt = ST_RUN;
      end
      ST_RUN: begin
        if (start_r) state_nxt = ST_CALC;
        else if (!tx_en_r && !rx_en_r) state_nxt = ST_IDLE;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= ST_IDLE;
      xport_r <= '{XM_SINGLE, 3'h1, RATE_6G};
      units_r <= `UNITS_6G;
    end else begin
      state_r <= state_nxt;
      if (state_r == ST_CALC) begin
        units_r <= units_now;
        xport_r <= plan_xport(units_now, mode_req_r, wires_r, tx_en_r);
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      conn_in_r <= 4'h0;
      conn_out_r <= 4'h0;
      tx_go_r <= 1'b0;
      rx_go_r <= 1'b0;
      conflict_r <= 1'b0;
      hdmi_full_res_r <= 1'b0;
      hdmi_downconv_r <= 1'b0;
    end else if (!running) begin
      conn_in_r <= 4'h0;
      conn_out_r <= 4'h0;
      tx_go_r <= 1'b0;
      rx_go_r <= 1'b0;
      hdmi_full_res_r <= 1'b0;
      hdmi_downconv_r <= 1'b0;
    end else begin
      tx_go_r <= tx_en_r && (shared || !rx_en_r);
      rx_go_r <= rx_en_r;
      conflict_r <= tx_en_r && rx_en_r && !shared;
      conn_in_r <= shared ? 4'h3 : (rx_en_r ? dir_mask : 4'h0);
      conn_out_r <= shared ? 4'hC : ((tx_en_r && !rx_en_r) ? dir_mask : 4'h0);
      hdmi_full_res_r <= rx_en_r && (xport_r.mode != XM_QUAD);
      hdmi_downconv_r <= rx_en_r && (xport_r.mode == XM_QUAD);
    end
  end
  assign conn_in = conn_in_r;
  assign conn_out = conn_out_r;
  assign hdmi_full_res = hdmi_full_res_r;
  assign hdmi_downconv = hdmi_downconv_r;

  // ***********************************************************
  // pixel clock sampling
  // ***********************************************************
  logic [SW-1:0] sync1_r, sync2_r;
  logic clk_d_r;
  wire [SW-1:0] sync_in = {pix_clk, pix_valid, pix_sof, pix_sol, pix_data, rx_valid,
                           rx_lane_data};
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_r <= '0;
      sync2_r <= '0;
      clk_d_r <= 1'b0;
    end else begin
      sync1_r <= sync_in;
      sync2_r <= sync1_r;
      clk_d_r <= sync2_r[SW-1];
    end
  end
  wire pix_rise = sync2_r[SW-1] && !clk_d_r;
  wire [`PIX_W+1:0] pix_word = sync2_r[SW-3 -: `PIX_W+2];
  wire s_pix_valid = sync2_r[SW-2];
  wire s_rx_valid = sync2_r[4*`PIX_W];
  wire [4*`PIX_W-1:0] s_rx_lanes = sync2_r[4*`PIX_W-1:0];
  wire push = pix_rise && s_pix_valid && tx_go_r;
  assign pix_ready = fifo_in_ready && tx_go_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ovf_r <= 1'b0;
    end else begin
      ovf_r <= (push && !fifo_in_ready) || (ovf_r && !(state_r == ST_CALC));
    end
  end

  // ***********************************************************
  // transmit split
  // ***********************************************************
  xfer_fifo #(.W(`PIX_W + 2), .D(`FIFO_DEPTH)) u_fifo (
    .clk(hclk),
    .rstn(hresetn),
    .in_valid(push),
    .in_ready(fifo_in_ready),
    .in_data(pix_word),
    .out_valid(fifo_out_valid),
    .out_ready(link_ready),
    .out_data(fifo_out_data)
  );

  logic [12:0] tx_x_r, tx_y_r;
  logic [4*`PIX_W-1:0] tx_data_r;
  logic [3:0] tx_valid_r;
  wire pop = fifo_out_valid && link_ready;
  wire f_sof = fifo_out_data[`PIX_W+1];
  wire f_sol = fifo_out_data[`PIX_W];
  wire [12:0] cur_x = (f_sof || f_sol) ? 13'h0000 : tx_x_r;
  wire [12:0] cur_y = f_sof ? 13'h0000 : (f_sol ? tx_y_r + 13'h0001 : tx_y_r);
  wire [1:0] tx_lane = lane_of(xport_r, cur_x, cur_y, halfw);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_x_r <= 13'h0000;
      tx_y_r <= 13'h0000;
      tx_data_r <= '0;
      tx_valid_r <= 4'h0;
    end else begin
      tx_valid_r <= 4'h0;
      if (pop) begin
        tx_x_r <= cur_x + 13'h0001;
        tx_y_r <= cur_y;
        tx_data_r[tx_lane*`PIX_W +: `PIX_W] <= fifo_out_data[`PIX_W-1:0];
        tx_valid_r <= 4'h1 << tx_lane;
      end
    end
  end
  assign tx_lane_data = tx_data_r;
  assign tx_lane_valid = tx_valid_r;

  // ***********************************************************
  // receive merge
  // ***********************************************************
  logic [12:0] rx_x_r, rx_y_r;
  logic [`PIX_W-1:0] rx_data_r;
  logic rx_vld_r;
  wire rx_take = pix_rise && s_rx_valid && rx_go_r;
  wire [1:0] rx_lane = lane_of(xport_r, rx_x_r, rx_y_r, halfw);
  wire rx_eol = (rx_x_r == {halfw[11:0], 1'b0} - 13'h0001);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_x_r <= 13'h0000;
      rx_y_r <= 13'h0000;
      rx_data_r <= '0;
      rx_vld_r <= 1'b0;
    end else begin
      rx_vld_r <= rx_take;
      if (!rx_go_r) begin
        rx_x_r <= 13'h0000;
        rx_y_r <= 13'h0000;
      end else if (rx_take) begin
        rx_data_r <= s_rx_lanes[rx_lane*`PIX_W +: `PIX_W];
        rx_x_r <= rx_eol ? 13'h0000 : rx_x_r + 13'h0001;
        rx_y_r <= !rx_eol ? rx_y_r : (rx_y_r == `FULL_H - 13'h0001) ? 13'h0000 :
                  rx_y_r + 13'h0001;
      end
    end
  end
  assign rx_pix_data = rx_data_r;
  assign rx_pix_valid = rx_vld_r;

  // ***********************************************************
  // assertions
  // ***********************************************************
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_single_2si;
    running && xport_r.mode == XM_SINGLE |-> xport_r.links == 3'h1 && xport_r.rate >= RATE_6G;
  endproperty
  a_single_2si: assert property (p_single_2si) else $error("single link not 6G or 12G");
  property p_rate_auto;
    running && xport_r.mode == XM_SINGLE |-> (xport_r.rate == RATE_12G) == (units_r > `UNITS_6G);
  endproperty
  a_rate_auto: assert property (p_rate_auto) else $error("single rate not from units");
  property p_quad_rate;
    running && xport_r.mode == XM_QUAD && xport_r.links == 3'h4 |->
      (units_r > `UNITS_6G) ? (xport_r.rate >= RATE_3G) : (xport_r.rate == RATE_1G5);
  endproperty
  a_quad_rate: assert property (p_quad_rate) else $error("quadrant link rate wrong");
  property p_quad_lane;
    pop && xport_r.mode == XM_QUAD && xport_r.links == 3'h4 && cur_x >= halfw &&
      cur_y < `HALF_H |=> tx_valid_r == 4'h2;
  endproperty
  a_quad_lane: assert property (p_quad_lane) else $error("upper right off link 1");
  property p_il_lane;
    pop && xport_r.mode == XM_INTERLEAVE && xport_r.links == 3'h4 && cur_x[0] && cur_y[0]
      |=> tx_valid_r == 4'h8;
  endproperty
  a_il_lane: assert property (p_il_lane) else $error("odd x odd y off link 3");
  property p_il_hfr;
    running && xport_r.mode == XM_INTERLEAVE && units_r > `UNITS_6G |-> xport_r.rate >= RATE_3G;
  endproperty
  a_il_hfr: assert property (p_il_hfr) else $error("interleave sub-stream below 3G");
  property p_fit;
    running && xport_r.links == 3'h1 |-> units_r <= `UNITS_12G;
  endproperty
  a_fit: assert property (p_fit) else $error("one link overloaded");
  property p_share;
    running && shared ##1 running && $stable(tx_en_r) |-> conn_in_r == 4'h3 && conn_out_r == 4'hC;
  endproperty
  a_share: assert property (p_share) else $error("shared connectors not split");
  property p_hfr_one;
    running && high_frame_rate && $past(high_frame_rate) |-> !((|conn_in_r) && (|conn_out_r));
  endproperty
  a_hfr_one: assert property (p_hfr_one) else $error("both directions at high rate");
  property p_hdmi;
    hdmi_full_res_r |-> xport_r.mode != XM_QUAD && !hdmi_downconv_r;
  endproperty
  a_hdmi: assert property (p_hdmi) else $error("quadrant input at full res on hdmi");
  property p_calc;
    state_r == ST_CALC |=> state_r != ST_IDLE && units_r == $past(units_now);
  endproperty
  a_calc: assert property (p_calc) else $error("plan not taken from format");

  c_quad4: cover property (pop && xport_r.mode == XM_QUAD && xport_r.links == 3'h4);
  c_rx_il: cover property (rx_take && xport_r.mode == XM_INTERLEAVE);
  c_shared: cover property (running && shared);
endmodule
`default_nettype wire

// [verif/sdi_far_end.sv]
// far-end sdi equipment model: link clock, lane sink pacing, receive lane source
`timescale 1ns/1ns
`default_nettype none
module sdi_far_end (
  // clock
  input wire logic hclk,
  // bench control
  input wire logic clk_run,
  input wire logic hold_off,
  input wire logic rx_go,
  // link side
  output logic pix_clk,
  output logic link_ready,
  output logic rx_valid,
  output logic [79:0] rx_lane_data
);
  logic [7:0] lfsr_r = 8'hA5;
  logic rv_r = 1'b0;
  logic [79:0] rd_r = 80'h0;
  int k = 0;
  // ***********************************************************
  // link clock, stands low outside frames
  // ***********************************************************
  initial begin
    pix_clk = 1'b0;
    forever begin
      #80;
      pix_clk = clk_run ? ~pix_clk : 1'b0;
    end
  end
  // ***********************************************************
  // lane sink stalls about one cycle in four
  // ***********************************************************
  always @(posedge hclk) begin
    lfsr_r <= {lfsr_r[6:0], lfsr_r[7] ^ lfsr_r[5] ^ lfsr_r[4] ^ lfsr_r[3]};
  end
  assign link_ready = !hold_off && (lfsr_r[1:0] != 2'h0);
  // ***********************************************************
  // receive lanes: lane n of word k (k-th pix_clk fall with rx_go) carries 4k+n
  // ***********************************************************
  always @(negedge pix_clk) begin
    if (rx_go) begin
      rv_r <= 1'b1;
      for (int n = 0; n < 4; n++) rd_r[20*n+:20] <= 20'(k * 4 + n);
      k = k + 1;
    end else begin
      rv_r <= 1'b0;
      rd_r <= ~rd_r;
    end
  end
  assign rx_valid = rv_r;
  assign rx_lane_data = rd_r;
endmodule
`default_nettype wire

// [verif/uhd_sdi_transport_link_mapper_tb.sv]
// testbench of the uhd sdi link mapper
`timescale 1ns/1ns
`default_nettype none
`include "uhd_link_map.svh"
module uhd_sdi_transport_link_mapper_tb;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, pix_clk, pix_valid, pix_sof, pix_sol;
  logic pix_ready, link_ready, rx_valid, rx_pix_valid, hdmi_full_res, hdmi_downconv;
  logic clk_run, hold_off, rx_go;
  logic [31:0] haddr, hwdata, hrdata, rd, seed, cfg, fmt;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [`PIX_W-1:0] pix_data, rx_pix_data;
  logic [79:0] tx_lane_data, rx_lane_data;
  logic [3:0] tx_lane_valid, conn_in, conn_out;
  logic [17:0] ex;
  logic [79:0] txq[$];
  logic [3:0] vq[$];
  logic [19:0] pq[$], rq[$];
  int mismatches = 0;
  int total_checks = 0;
  int cycles = 0;
  uhd_sdi_transport_link_mapper dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .pix_clk(pix_clk), .pix_valid(pix_valid), .pix_sof(pix_sof), .pix_sol(pix_sol),
    .pix_data(pix_data), .pix_ready(pix_ready), .tx_lane_data(tx_lane_data),
    .tx_lane_valid(tx_lane_valid), .link_ready(link_ready), .rx_valid(rx_valid),
    .rx_lane_data(rx_lane_data), .rx_pix_data(rx_pix_data), .rx_pix_valid(rx_pix_valid),
    .conn_in(conn_in), .conn_out(conn_out), .hdmi_full_res(hdmi_full_res),
    .hdmi_downconv(hdmi_downconv));
  sdi_far_end far (.hclk(hclk), .clk_run(clk_run), .hold_off(hold_off), .rx_go(rx_go),
    .pix_clk(pix_clk), .link_ready(link_ready), .rx_valid(rx_valid),
    .rx_lane_data(rx_lane_data));
  // ***********************************************************
  // clock, timeout, lane monitors
  // ***********************************************************
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      end_sim();
    end
    if (tx_lane_valid !== 4'h0) begin
      vq.push_back(tx_lane_valid);
      txq.push_back(tx_lane_data);
    end
    if (rx_pix_valid === 1'b1) rq.push_back(rx_pix_data);
  end
  // ***********************************************************
  // helpers
  // ***********************************************************
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  // expected {conn_out, conn_in, status[9:0]} of a control and format word
  function automatic logic [17:0] expect_plan(input logic [31:0] c, input logic [31:0] f);
    logic [4:0] u, per;
    logic [2:0] l;
    logic [1:0] m, r;
    logic tx, rx, sh;
    logic [3:0] mk;
    tx = c[1];
    rx = c[2];
    u = (f[2:1] == `DEPTH_12 || f[4:3] == `CHROMA_444) ? `UNITS_12G : `UNITS_6G;
    if (f[0]) u = u << 1;
    if (c[4:3] == `MODE_INTERLEAVE) begin
      m = 2'h2;
      l = (u <= 5'h08) ? 3'h2 : 3'h4;
    end else if (c[4:3] == `MODE_QUAD || (tx && c[6:5] != `WIRES_AUTO)) begin
      m = 2'h1;
      l = (c[6:5] == `WIRES_TWO && u <= 5'h08) ? 3'h2 : 3'h4;
    end else if (u > 5'h08) begin
      m = 2'h2;
      l = 3'h2;
    end else begin
      m = 2'h0;
      l = 3'h1;
    end
    per = u / 5'(l);
    r = (per <= 5'h01) ? 2'h0 : (per <= 5'h02) ? 2'h1 : (per <= 5'h04) ? 2'h2 : 2'h3;
    sh = tx && rx && !f[0] && l <= 3'h2;
    mk = (f[0] || l == 3'h4) ? 4'hF : (l == 3'h2) ? 4'h3 : 4'h1;
    return {sh ? 4'hC : (tx && !rx) ? mk : 4'h0, sh ? 4'h3 : rx ? mk : 4'h0,
      rx && m != 2'h1, m, r, l, tx && rx && !sh, 1'b1};
  endfunction
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd,
    output logic [31:0] rdv);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rdv = hrdata;
    check("hresp", {31'h0, hresp}, 32'h0);
  endtask
  task automatic send_pix(input logic v, input logic s, input logic l, input logic [19:0] d);
    @(negedge pix_clk);
    @(posedge hclk);
    pix_valid <= v;
    pix_sof <= s;
    pix_sol <= l;
    pix_data <= d;
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // ***********************************************************
  // main sequence
  // ***********************************************************
  initial begin
    hresetn = 1'b0;
    {hsel, hwrite, pix_valid, pix_sof, pix_sol, clk_run, hold_off, rx_go} = 8'h00;
    {haddr, hwdata, htrans, pix_data} = '0;
    hsize = 3'h2;
    seed = 32'h0000_4D7A;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(1'b0, `ADDR_CTRL, 32'h0, rd);
    check("ctrl reset", rd, `CTRL_RST);
    ahb(1'b0, `ADDR_FMT, 32'h0, rd);
    check("fmt reset", rd, 32'(`FMT_RST));
    ahb(1'b0, 32'h10, 32'h0, rd);
    check("unmapped read", rd, 32'h0);
    ahb(1'b0, `ADDR_STATUS, 32'h0, rd);
    check("status idle", rd, {23'h0, 2'h0, 2'h2, 3'h1, 2'h0});
    // link planning and connector use over corners and random formats
    for (int i = 0; i < 30; i++) begin
      seed = xs(seed);
      cfg = {25'h0, seed[1:0] % 2'h3, seed[3:2] % 2'h3, 2'h0, 1'b1};
      cfg[2:1] = (seed[5:4] == 2'h0) ? 2'h3 : seed[5:4];
      fmt = {26'h0, seed[11], seed[10:9] % 2'h3, seed[8:7] % 2'h3, seed[6]};
      case (i)
        0: {cfg, fmt} = {32'h0B, 32'h00};
        1: {cfg, fmt} = {32'h33, 32'h05};
        2: {cfg, fmt} = {32'h07, 32'h04};
        default: ;
      endcase
      ahb(1'b1, `ADDR_FMT, fmt, rd);
      ahb(1'b1, `ADDR_CTRL, cfg, rd);
      repeat (4) @(posedge hclk);
      ex = expect_plan(cfg, fmt);
      ahb(1'b0, `ADDR_STATUS, 32'h0, rd);
      check("plan", {22'h0, rd[9:0]}, {22'h0, ex[9:0]});
      check("links", {29'h0, rd[4:2]}, {29'h0, ex[4:2]});
      ahb(1'b0, `ADDR_CONN, 32'h0, rd);
      check("conn reg", rd, {24'h0, ex[17:10]});
      check("conn pins", {24'h0, conn_out, conn_in}, {24'h0, ex[17:10]});
      check("pix ready", {31'h0, pix_ready}, {31'h0, |ex[17:14]});
      check("hdmi", {30'h0, hdmi_full_res, hdmi_downconv},
        {30'h0, ex[9], cfg[2] && ex[8:7] == 2'h1});
    end
    // transmit split into four interleaved lanes, fifo filled past full then drained
    hold_off <= 1'b1;
    clk_run <= 1'b1;
    ahb(1'b1, `ADDR_FMT, 32'h05, rd);
    ahb(1'b1, `ADDR_CTRL, 32'h13, rd);
    vq.delete();
    for (int i = 0; i < 20; i++) begin
      seed = xs(seed);
      send_pix(1'b1, i == 0, i == 8, seed[19:0]);
      if (i < `FIFO_DEPTH) pq.push_back(seed[19:0]);
    end
    send_pix(1'b0, 1'b0, 1'b0, 20'h0);
    repeat (8) @(posedge hclk);
    ahb(1'b0, `ADDR_STATUS, 32'h0, rd);
    check("fifo full and overflow", {30'h0, rd[11:10]}, 32'h3);
    hold_off <= 1'b0;
    for (int w = 0; w < 300 && vq.size() < `FIFO_DEPTH; w++) @(posedge hclk);
    repeat (20) @(posedge hclk);
    check("lane count", vq.size(), `FIFO_DEPTH);
    for (int j = 0; j < vq.size() && j < `FIFO_DEPTH; j++) begin
      check("lane valid", {28'h0, vq[j]}, 32'h1 << ((j / 8) * 2 + j % 2));
      check("lane data", {12'h0, txq[j][20*((j/8)*2+j%2)+:20]}, {12'h0, pq[j]});
    end
    // receive merge of interleaved lanes
    ahb(1'b1, `ADDR_CTRL, 32'h15, rd);
    repeat (6) @(posedge hclk);
    rx_go <= 1'b1;
    for (int w = 0; w < 400 && rq.size() < 6; w++) @(posedge hclk);
    rx_go <= 1'b0;
    check("rx count", rq.size() >= 6, 32'h1);
    for (int j = 0; j < 6 && j < rq.size(); j++) begin
      check("rx pixel", {12'h0, rq[j]}, 32'(4 * j + j % 2));
    end
    end_sim();
  end
endmodule
`default_nettype wire
